// File: src/isu_slave.sv
/*
 Slave side of the serial bus unit: bit engine on sampled line levels,
 APB register slave, status flags and wake request.
 Assumes clock and data lines arrive asynchronously and are open drain.
*/
`timescale 1ns/1ps
module isu_slave (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_clock_line,
	input wire logic serial_data_line,
	output logic scl_out,
	output logic scl_oe,
	output logic sda_out,
	output logic sda_oe,
	output logic irq,
	output logic wake_req
);
	// This engine is bus unit zero; the other units stay master only
	// Bit engine phases
	typedef enum logic [2:0] {ISU_IDLE, ISU_ADDR, ISU_ACK, ISU_WAIT, ISU_DATA}
		isu_phase_t;

	// Two-stage synchronisers for both lines
	logic [1:0] scl_sync_reg, scl_sync_next, sda_sync_reg, sda_sync_next;
	logic scl_d_reg, scl_d_next, sda_d_reg, sda_d_next;
	// Registers and state
	logic [15:0] ctrl_reg, ctrl_next;
	isu_pkg::isu_stat_t stat_reg, stat_next;
	logic [7:0] rxd_reg, rxd_next, txd_reg, txd_next, shf_reg, shf_next;
	logic [3:0] cnt_reg, cnt_next;
	isu_phase_t ph_reg, ph_next;
	logic ackd_reg, ackd_next; // Ack bit being driven
	logic dis_reg, dis_next; // Data output disabled by mismatch
	logic rd_reg, rd_next; // Master reads from us
	logic [31:0] prdata_next;
	logic irq_next, wake_next, scl_oe_next, sda_oe_next;

	logic scl_rise, scl_fall, start_c, stop_c, wr_acc, rd_acc;
	logic [7:0] clr_bits;
	logic deep;
	logic tx_hold; // Keep the data bit while the clock is high

	// Edge and condition detection on synchronised levels only
	always_comb begin
		scl_sync_next = {scl_sync_reg[0], serial_clock_line};
		sda_sync_next = {sda_sync_reg[0], serial_data_line};
		scl_d_next = scl_sync_reg[1];
		sda_d_next = sda_sync_reg[1];
		// Edges compare the second stage with its delayed copy
		scl_rise = scl_sync_reg[1] & ~scl_d_reg;
		scl_fall = ~scl_sync_reg[1] & scl_d_reg;
		// Data moving while the clock stays high marks a start or a stop
		start_c = scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1];
		stop_c = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];
	end

	// APB decode; one wait-free access phase
	always_comb begin
		wr_acc = psel & penable & pwrite;
		rd_acc = psel & ~penable & ~pwrite;
		clr_bits = (wr_acc && paddr == isu_pkg::ISU_CLR_OFS) ? pwdata[7:0] : 8'h00;
		deep = ctrl_reg[isu_pkg::ISU_C_DEEP];
		ctrl_next = (wr_acc && paddr == isu_pkg::ISU_CTRL_OFS) ? pwdata[15:0] : ctrl_reg;
		txd_next = (wr_acc && paddr == isu_pkg::ISU_TXD_OFS) ? pwdata[7:0] : txd_reg;
		prdata_next = prdata;
		// Read data is captured in setup, so it stands through the access
		// phase and the slave never needs a wait state
		if (rd_acc) begin
			unique case (paddr)
				isu_pkg::ISU_CTRL_OFS: prdata_next = {16'h0000, ctrl_reg};
				isu_pkg::ISU_STAT_OFS: prdata_next = {22'h0, stat_reg};
				isu_pkg::ISU_DATA_OFS: prdata_next = {24'h000000, rxd_reg};
				isu_pkg::ISU_TXD_OFS: prdata_next = {24'h000000, txd_reg};
				default: prdata_next = 32'h00000000;
			endcase
		end
	end

	// Bit engine and status flags; hardware sets win over clears
	always_comb begin
		ph_next = ph_reg;
		cnt_next = cnt_reg;
		shf_next = shf_reg;
		rxd_next = rxd_reg;
		ackd_next = ackd_reg;
		dis_next = dis_reg;
		rd_next = rd_reg;
		stat_next = stat_reg;
		wake_next = 1'b0;
		// Software clears first, events below override
		if (clr_bits[isu_pkg::ISU_K_ER]) begin
			stat_next.bit_mismatch_error = 1'b0;
		end
		if (clr_bits[isu_pkg::ISU_K_ACR]) begin
			stat_next.ack_level_seen = 1'b0;
		end
		if (clr_bits[isu_pkg::ISU_K_FLAGS]) begin
			stat_next.start_seen_flag = 1'b0;
			stat_next.address_match_flag = 1'b0;
			stat_next.sleep_match_nack_flag = 1'b0;
			stat_next.data_done_flag = 1'b0;
			stat_next.stop_seen_flag = 1'b0;
			stat_next.released_by_restart_flag = 1'b0;
		end
		if (!ctrl_reg[isu_pkg::ISU_C_EN]) begin
			ph_next = ISU_IDLE;
		end else if (stop_c) begin
			// Stop ends any transfer
			if (ctrl_reg[isu_pkg::ISU_C_MD4]) begin
				stat_next.stop_seen_flag = 1'b1;
				if (stat_reg.slave_addressed_flag && !ctrl_reg[isu_pkg::ISU_C_MD1]) begin
					stat_next.address_match_flag = 1'b1;
				end
			end
			stat_next.slave_addressed_flag = 1'b0;
			stat_next.transmitting = 1'b0;
			ph_next = ISU_IDLE;
			dis_next = 1'b0;
			ackd_next = 1'b0;
		end else if (start_c) begin
			// Start or restart begins address reception
			if (ctrl_reg[isu_pkg::ISU_C_MD5]) begin
				stat_next.start_seen_flag = 1'b1;
			end
			ph_next = ISU_ADDR;
			cnt_next = 4'h0;
			dis_next = 1'b0;
			ackd_next = 1'b0;
		end else begin
			unique case (ph_reg)
				ISU_IDLE: begin
					ph_next = ISU_IDLE;
				end
				ISU_ADDR: begin
					if (scl_rise) begin
						shf_next = {shf_reg[6:0], sda_sync_reg[1]};
						cnt_next = cnt_reg + 4'h1;
					end
					if (scl_fall && cnt_reg == 4'h8) begin
						if (shf_reg[7:1] == ctrl_reg[isu_pkg::ISU_C_ADDR +: isu_pkg::ISU_AW]) begin
							// Ack level: low normally, high when in deep sleep
							ackd_next = deep;
							rd_next = shf_reg[0];
							wake_next = 1'b1;
							if (deep) begin
								stat_next.sleep_match_nack_flag = 1'b1;
								ph_next = ISU_IDLE;
							end else begin
								stat_next.address_match_flag = 1'b1;
								// Busy from match to stop or to a restart with another address, for firmware to poll
								stat_next.slave_addressed_flag = 1'b1;
								ph_next = ISU_ACK;
							end
						end else begin
							if (stat_reg.slave_addressed_flag && ctrl_reg[isu_pkg::ISU_C_MD3]) begin
								stat_next.released_by_restart_flag = 1'b1;
							end
							stat_next.slave_addressed_flag = 1'b0;
							ph_next = ISU_IDLE;
						end
					end
				end
				ISU_ACK: begin
					// Ack bit clock fall ends the byte
					if (scl_fall) begin
						ackd_next = 1'b0;
						ph_next = ISU_WAIT;
						// Byte reaches software only once the ack bit is over
						if (!rd_reg && cnt_reg == 4'h9) begin
							rxd_next = shf_reg;
						end
						stat_next.transmitting = rd_reg;
						if (stat_reg.slave_addressed_flag && cnt_reg == 4'h9) begin
							stat_next.data_done_flag = 1'b1;
						end
					end
				end
				ISU_WAIT: begin
					// Clock held low until software resumes
					if (ctrl_reg[isu_pkg::ISU_C_RESUME]) begin
						ph_next = ISU_DATA;
						cnt_next = 4'h0;
						shf_next = txd_reg;
						dis_next = 1'b0;
					end
				end
				ISU_DATA: begin
					if (scl_rise) begin
						if (rd_reg && !dis_reg && sda_sync_reg[1] != shf_reg[7]) begin
							stat_next.bit_mismatch_error = 1'b1;
							dis_next = 1'b1;
						end
						shf_next = {shf_reg[6:0], sda_sync_reg[1]};
						cnt_next = cnt_reg + 4'h1;
					end
					if (scl_fall && cnt_reg == 4'h8) begin
						cnt_next = 4'h9;
						ph_next = ISU_ACK;
						if (!rd_reg) begin
							// Received byte: answer with the chosen level
							ackd_next = ctrl_reg[isu_pkg::ISU_C_ACK];
							stat_next.ack_level_seen = ctrl_reg[isu_pkg::ISU_C_ACK];
						end else begin
							// Sent byte: let go so the master can answer
							ackd_next = 1'b1;
						end
					end
				end
				default: ph_next = ISU_IDLE;
			endcase
		end
		// Pin drives: ack low when ack value 0, data bits when reading
		// A data bit changes only while the clock is low; moving it while
		// the clock is high would look like a start or a stop on the bus
		tx_hold = (ph_reg == ISU_DATA) && scl_sync_reg[1];
		sda_oe_next = ((ph_next == ISU_ACK) && !ackd_next) ||
			(ph_next == ISU_DATA && rd_next && !dis_next &&
			(tx_hold ? sda_oe : !shf_next[7]));
		scl_oe_next = (ph_next == ISU_WAIT);
		irq_next = stat_next.start_seen_flag | stat_next.address_match_flag |
			stat_next.sleep_match_nack_flag | stat_next.data_done_flag |
			stat_next.stop_seen_flag | stat_next.released_by_restart_flag;
	end

	// Register update; reset loads constants only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Lines idle high, so no false edge follows reset
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			ctrl_reg <= isu_pkg::ISU_CTRL_RST;
			stat_reg <= isu_pkg::ISU_STAT_RST;
			rxd_reg <= 8'h00;
			txd_reg <= 8'h00;
			shf_reg <= 8'h00;
			cnt_reg <= 4'h0;
			ph_reg <= ISU_IDLE;
			ackd_reg <= 1'b0;
			dis_reg <= 1'b0;
			rd_reg <= 1'b0;
			// Outputs start released and quiet
			prdata <= 32'h00000000;
			irq <= 1'b0;
			wake_req <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			// Line samplers
			scl_sync_reg <= scl_sync_next;
			sda_sync_reg <= sda_sync_next;
			scl_d_reg <= scl_d_next;
			sda_d_reg <= sda_d_next;
			ctrl_reg <= ctrl_next;
			stat_reg <= stat_next;
			rxd_reg <= rxd_next;
			txd_reg <= txd_next;
			shf_reg <= shf_next;
			cnt_reg <= cnt_next;
			ph_reg <= ph_next;
			ackd_reg <= ackd_next;
			dis_reg <= dis_next;
			rd_reg <= rd_next;
			// Outputs toward the bus and the pins
			prdata <= prdata_next;
			irq <= irq_next;
			wake_req <= wake_next;
			scl_oe <= scl_oe_next;
			sda_oe <= sda_oe_next;
		end
	end

	// Open-drain lines only ever pull low; fixed-ready APB
	always_comb begin
		scl_out = 1'b0;
		sda_out = 1'b0;
		pready = 1'b1;
		pslverr = 1'b0;
	end

	// Checks
	// Antecedents leave out start, stop and a disabled unit, since those
	// override the phase logic in the same cycle
	chk_mismatch_err: assert property (@(posedge pclk) disable iff (!presetn)
		(ph_reg == ISU_DATA && rd_reg && !dis_reg && scl_rise && !start_c && !stop_c
		&& ctrl_reg[0] && sda_sync_reg[1] != shf_reg[7]) |=> stat_reg.bit_mismatch_error)
		else $error("mismatch not flagged");
	chk_wait_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(ph_reg == ISU_WAIT) |-> scl_oe) else $error("clock not held in wait");
	chk_stop_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(stop_c && ctrl_reg[0] && ctrl_reg[isu_pkg::ISU_C_MD4]) |=> stat_reg.stop_seen_flag)
		else $error("stop flag missing");
	chk_err_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(clr_bits[isu_pkg::ISU_K_ER] && ph_reg != ISU_DATA) |=> !stat_reg.bit_mismatch_error)
		else $error("error not cleared");
	chk_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
		stat_reg.data_done_flag |-> irq) else $error("irq missing");
	chk_deep_nack: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(stat_reg.sleep_match_nack_flag) |-> !sda_oe && wake_req)
		else $error("deep match acked low");
	chk_start_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(start_c && !stop_c && ctrl_reg[0] && ctrl_reg[isu_pkg::ISU_C_MD5])
		|=> stat_reg.start_seen_flag) else $error("start flag missing");
	chk_wait_entry: assert property (@(posedge pclk) disable iff (!presetn)
		(ph_reg == ISU_ACK && scl_fall && !start_c && !stop_c && ctrl_reg[0])
		|=> ph_reg == ISU_WAIT) else $error("no wait after ack");
	// Own address in normal mode is answered with a low ack
	chk_addr_ack_low: assert property (@(posedge pclk) disable iff (!presetn)
		(ph_reg == ISU_ADDR && scl_fall && cnt_reg == 4'h8 && !start_c && !stop_c && ctrl_reg[0]
		&& !deep && shf_reg[7:1] == ctrl_reg[isu_pkg::ISU_C_ADDR +: isu_pkg::ISU_AW]) |=> sda_oe)
		else $error("address match not acked low");
	// Received byte copied when the ack bit ends
	chk_rx_copy: assert property (@(posedge pclk) disable iff (!presetn)
		(ph_reg == ISU_ACK && scl_fall && !rd_reg && cnt_reg == 4'h9 && !start_c && !stop_c
		&& ctrl_reg[0]) |=> rxd_reg == $past(shf_reg)) else $error("received byte not copied");
	// Ack level sent is recorded in status
	chk_ack_record: assert property (@(posedge pclk) disable iff (!presetn)
		(ph_reg == ISU_DATA && !rd_reg && scl_fall && cnt_reg == 4'h8 && !start_c && !stop_c
		&& ctrl_reg[0]) |=> stat_reg.ack_level_seen == $past(ctrl_reg[isu_pkg::ISU_C_ACK]))
		else $error("ack level not recorded");
	// Wake request is a single-cycle pulse
	chk_wake_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		wake_req |=> !wake_req) else $error("wake request too long");
	cov_match: cover property (@(posedge pclk) $rose(stat_reg.address_match_flag));
	cov_stop: cover property (@(posedge pclk) $rose(stat_reg.stop_seen_flag));
	cov_release: cover property (@(posedge pclk) $rose(stat_reg.released_by_restart_flag));
	cov_sleep: cover property (@(posedge pclk) $rose(stat_reg.sleep_match_nack_flag));
	cov_data: cover property (@(posedge pclk) $rose(stat_reg.data_done_flag));
endmodule

// File: src/isu_pkg.sv
/*
 Shared constants and types of the serial-bus slave unit: register offsets,
 field positions, reset values and the status carrier.
 Assumes a 32-bit APB master on the system clock.
*/
package isu_pkg;
	// Register byte offsets
	localparam logic [7:0] ISU_CTRL_OFS = 8'h00;
	localparam logic [7:0] ISU_STAT_OFS = 8'h04;
	localparam logic [7:0] ISU_CLR_OFS = 8'h08;
	localparam logic [7:0] ISU_DATA_OFS = 8'h0C;
	localparam logic [7:0] ISU_TXD_OFS = 8'h10;
	// Control field positions
	localparam int ISU_C_EN = 0;
	localparam int ISU_C_MD1 = 1;
	localparam int ISU_C_MD3 = 3;
	localparam int ISU_C_MD4 = 4;
	localparam int ISU_C_MD5 = 5;
	localparam int ISU_C_ACK = 6;
	localparam int ISU_C_DEEP = 7;
	localparam int ISU_C_RESUME = 8;
	localparam int ISU_C_ADDR = 9;
	localparam logic [15:0] ISU_CTRL_RST = 16'h0000;
	// Clear register field positions
	localparam int ISU_K_ACR = 1;
	localparam int ISU_K_ER = 2;
	localparam int ISU_K_FLAGS = 5;
	// Address width and data width
	localparam int ISU_AW = 7;
	localparam int ISU_DW = 8;
	// Status carrier
	typedef struct packed {
		logic released_by_restart_flag;
		logic stop_seen_flag;
		logic data_done_flag;
		logic sleep_match_nack_flag;
		logic address_match_flag;
		logic start_seen_flag;
		logic slave_addressed_flag;
		logic bit_mismatch_error;
		logic ack_level_seen;
		logic transmitting;
	} isu_stat_t;
	localparam isu_stat_t ISU_STAT_RST = '0;
endpackage

// File: tb/isu_i2c_master.sv
/*
 Behavioural bus master facing the slave unit across the serial lines.
 Assumes the bench resolves both open-drain wires with pull-ups.
*/
`timescale 1ns/1ps
module isu_i2c_master (
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_pull,
	output logic sda_pull
);
	// Idle with both lines released; the clock stands still between frames
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	// Release clock, bounded wait while the slave stretches it
	task automatic rise();
		scl_pull = 1'b0;
		for (int i = 0; i < 5000 && scl_in !== 1'b1; i++) #10;
		#40;
	endtask
	// Start or repeated start: data falls while clock high
	task automatic start_c();
		#3;
		sda_pull = 1'b0;
		#40;
		rise();
		sda_pull = 1'b1;
		#40;
		scl_pull = 1'b1;
		#40;
	endtask
	// Stop: data rises while clock high
	task automatic stop_c();
		#3;
		sda_pull = 1'b1;
		#40;
		rise();
		sda_pull = 1'b0;
		#40;
	endtask
	// One bit of 160 ns; sampled mid high phase
	task automatic bit_x(input logic b, output logic s);
		sda_pull = ~b;
		#40;
		rise();
		s = sda_in;
		#40;
		scl_pull = 1'b1;
		#40;
	endtask
	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
		output logic ack_rx);
		logic s;
		#3;
		for (int i = 7; i >= 0; i--) begin
			bit_x(tx[i], s);
			rx = {rx[6:0], s};
		end
		bit_x(ack_tx, ack_rx);
	endtask
endmodule

// File: tb/test_isu_slave.sv
/*
 Self-checking bench of the slave unit: APB tasks and bus master calls.
 Assumes the wires are pulled up and only pulled low by either party.
*/
`timescale 1ns/1ps
module test_isu_slave;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq, wake_req;
	logic m_scl, m_sda;
	// Wired-AND of both parties
	wire scl_w = ~(m_scl | scl_oe);
	wire sda_w = ~(m_sda | sda_oe);
	int err_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int wakes = 0;
	int w;
	logic [31:0] ctl, rd;
	logic [7:0] rx;
	logic ak;
	isu_pkg::isu_stat_t st;
	localparam logic [31:0] FL = 32'h20; // All event flags clear
	always #5 pclk = ~pclk;
	isu_slave u_isu_slave (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_clock_line(scl_w), .serial_data_line(sda_w),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq),
		.wake_req(wake_req));
	isu_i2c_master u_isu_i2c_master (.scl_in(scl_w), .sda_in(sda_w), .scl_pull(m_scl),
		.sda_pull(m_sda));
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Wake pulse count and hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (wake_req === 1'b1) begin
			wakes <= wakes + 1;
		end
		if (cyc == 60000) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wctl(input logic [31:0] d);
		apb(1'b1, isu_pkg::ISU_CTRL_OFS, d);
	endtask
	task automatic clr(input logic [31:0] d);
		apb(1'b1, isu_pkg::ISU_CLR_OFS, d);
	endtask
	task automatic rs();
		apb(1'b0, isu_pkg::ISU_STAT_OFS, 32'h0);
		st = isu_pkg::isu_stat_t'(rd[9:0]);
	endtask
	// Pulse resume so the held clock is let go
	task automatic go_on();
		clr(FL);
		wctl(ctl | (32'h1 << isu_pkg::ISU_C_RESUME));
		for (int i = 0; i < 50 && scl_oe !== 1'b0; i++) begin
			@(posedge pclk);
			#1;
		end
		check("clock release", 32'(scl_oe), 32'h0);
		wctl(ctl);
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// Own address 2A; enable, restart, stop and start interrupts on
		ctl = (32'h2A << isu_pkg::ISU_C_ADDR) | 32'h39;
		wctl(ctl);
		u_isu_i2c_master.start_c();
		rs();
		check("start flag", 32'(st.start_seen_flag), 32'h1);
		check("irq start", 32'(irq), 32'h1);
		clr(FL);
		u_isu_i2c_master.xfer(8'h54, 1'b1, rx, ak);
		check("addr ack", 32'(ak), 32'h0);
		rs();
		check("match flag", 32'(st.address_match_flag), 32'h1);
		check("clock held", 32'(scl_oe), 32'h1);
		go_on();
		u_isu_i2c_master.xfer(8'hA5, 1'b1, rx, ak);
		check("ack low", 32'(ak), 32'h0);
		apb(1'b0, isu_pkg::ISU_DATA_OFS, 32'h0);
		check("byte A5", rd, 32'hA5);
		rs();
		check("data flag", 32'(st.data_done_flag), 32'h1);
		check("ack seen 0", 32'(st.ack_level_seen), 32'h0);
		check("wait hold", 32'(scl_oe), 32'h1);
		// Next byte answered with a high acknowledge
		ctl = ctl | (32'h1 << isu_pkg::ISU_C_ACK);
		go_on();
		u_isu_i2c_master.xfer(8'h3C, 1'b1, rx, ak);
		check("ack high", 32'(ak), 32'h1);
		apb(1'b0, isu_pkg::ISU_DATA_OFS, 32'h0);
		check("byte 3C", rd, 32'h3C);
		rs();
		check("ack seen 1", 32'(st.ack_level_seen), 32'h1);
		ctl = ctl ^ (32'h1 << isu_pkg::ISU_C_ACK);
		go_on();
		// Restart towards another slave
		u_isu_i2c_master.start_c();
		u_isu_i2c_master.xfer(8'h22, 1'b1, rx, ak);
		rs();
		check("released flag", 32'(st.released_by_restart_flag), 32'h1);
		check("other no ack", 32'(ak), 32'h1);
		u_isu_i2c_master.stop_c();
		$display("test receive done");
		// Stop while addressed
		clr(FL);
		u_isu_i2c_master.start_c();
		u_isu_i2c_master.xfer(8'h54, 1'b1, rx, ak);
		go_on();
		u_isu_i2c_master.stop_c();
		rs();
		check("stop flag", 32'(st.stop_seen_flag), 32'h1);
		check("stop match", 32'(st.address_match_flag), 32'h1);
		check("irq stop", 32'(irq), 32'h1);
		$display("test stop done");
		// Slave sends C3, master pulls bit 7 low
		clr(FL);
		apb(1'b1, isu_pkg::ISU_TXD_OFS, 32'hC3);
		u_isu_i2c_master.start_c();
		u_isu_i2c_master.xfer(8'h55, 1'b1, rx, ak);
		check("read ack", 32'(ak), 32'h0);
		go_on();
		u_isu_i2c_master.xfer(8'h7F, 1'b1, rx, ak);
		check("output off", 32'(rx), 32'h7F);
		rs();
		check("error flag", 32'(st.bit_mismatch_error), 32'h1);
		check("tx data flag", 32'(st.data_done_flag), 32'h1);
		clr(32'h1 << isu_pkg::ISU_K_ER);
		rs();
		check("error clear", 32'(st.bit_mismatch_error), 32'h0);
		go_on();
		u_isu_i2c_master.stop_c();
		$display("test mismatch done");
		// Deep standby match answered high, then repeated
		ctl = ctl | (32'h1 << isu_pkg::ISU_C_DEEP);
		wctl(ctl);
		clr(FL);
		w = wakes;
		u_isu_i2c_master.start_c();
		u_isu_i2c_master.xfer(8'h54, 1'b1, rx, ak);
		check("deep ack", 32'(ak), 32'h1);
		rs();
		check("sleep flag", 32'(st.sleep_match_nack_flag), 32'h1);
		check("wake pulse", 32'(wakes - w), 32'h1);
		u_isu_i2c_master.stop_c();
		ctl = ctl ^ (32'h1 << isu_pkg::ISU_C_DEEP);
		wctl(ctl);
		repeat (20) @(posedge pclk);
		u_isu_i2c_master.start_c();
		u_isu_i2c_master.xfer(8'h54, 1'b1, rx, ak);
		check("retry ack", 32'(ak), 32'h0);
		go_on();
		u_isu_i2c_master.stop_c();
		$display("test wake done");
		print_verdict();
	end
endmodule
